// >>> core/t16ic_timer.sv
// Sixteen-bit free-running timer with two input capture channels and a Wishbone slave.
`timescale 1ns/1ps

module t16ic_timer #(
  parameter bit CAP1_BONDED = 1'b1,
  parameter bit CAP2_BONDED = 1'b1,
  parameter bit EXT_BONDED  = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        irq_mask,
  input  wire logic        halt_mode,
  input  wire logic        capture_pin_one,
  input  wire logic        capture_pin_two,
  input  wire logic        ext_clock_pin,
  output logic             overflow_irq,
  output logic             capture_irq
);
  // ==========================================================================
  // Bus decode
  // ==========================================================================
  logic        ack_r;
  logic [7:0]  rdata;
  logic [7:0]  control_reg_one_r;
  logic [7:0]  control_reg_two_r;
  logic [15:0] count_r;
  logic        overflow_flag_r;
  logic        ovf_arm_r;
  logic [7:0]  lat_r;
  logic        lat_v_r;
  logic [2:0]  psc_r;
  logic [15:0] cap_r [2];
  logic [1:0]  cap_flag_r;
  logic [1:0]  cap_arm_r;
  logic [1:0]  cap_blk_r;
  logic [1:0]  cap_ev;

  wire acc        = wb_cyc_i & wb_stb_i & ~ack_r;
  wire rd         = acc & ~wb_we_i;
  wire wr         = acc & wb_we_i & wb_sel_i[0];
  wire hit_cr1    = wb_adr_i == t16ic_pkg::ADR_CTRL1;
  wire hit_cr2    = wb_adr_i == t16ic_pkg::ADR_CTRL2;
  wire hit_sr     = wb_adr_i == t16ic_pkg::ADR_STATUS;
  wire hit_cnt_hi = wb_adr_i == t16ic_pkg::ADR_CNT_HI;
  wire hit_cnt_lo = wb_adr_i == t16ic_pkg::ADR_CNT_LO;
  wire hit_alt_hi = wb_adr_i == t16ic_pkg::ADR_ALT_HI;
  wire hit_alt_lo = wb_adr_i == t16ic_pkg::ADR_ALT_LO;
  wire [1:0] hit_cap_hi = {wb_adr_i == t16ic_pkg::ADR_CAP2_HI,
                           wb_adr_i == t16ic_pkg::ADR_CAP1_HI};
  wire [1:0] hit_cap_lo = {wb_adr_i == t16ic_pkg::ADR_CAP2_LO,
                           wb_adr_i == t16ic_pkg::ADR_CAP1_LO};
  wire rd_hi      = rd & (hit_cnt_hi | hit_alt_hi);
  wire rd_lo      = rd & (hit_cnt_lo | hit_alt_lo);
  wire reload     = wr & (hit_cnt_lo | hit_alt_lo);
  wire rd_sr      = rd & hit_sr;

  // ==========================================================================
  // Control fields
  // ==========================================================================
  wire [1:0] timer_clock_select = control_reg_two_r[t16ic_pkg::CR2_CLKSEL_HI:t16ic_pkg::CR2_CLKSEL_LO];
  wire overflow_irq_enable   = control_reg_one_r[t16ic_pkg::CR1_OVF_IRQ_EN];
  wire capture_irq_enable    = control_reg_one_r[t16ic_pkg::CR1_CAP_IRQ_EN];
  wire capture_edge_one      = control_reg_one_r[t16ic_pkg::CR1_CAP_EDGE1];
  wire capture_edge_two      = control_reg_two_r[t16ic_pkg::CR2_CAP_EDGE2];
  wire ext_clock_edge_select = control_reg_two_r[t16ic_pkg::CR2_EXT_EDGE];
  wire one_pulse_select      = control_reg_two_r[t16ic_pkg::CR2_ONE_PULSE];
  wire pwm_select            = control_reg_two_r[t16ic_pkg::CR2_PWM];
  wire ext_mode              = timer_clock_select == t16ic_pkg::CLK_EXT;

  // ==========================================================================
  // Pin synchronisers and edge detectors
  // ==========================================================================
  // Index 0 and 1 are the capture pins, index 2 the external clock pin.
  wire [2:0] pin_in = {EXT_BONDED  ? ext_clock_pin   : 1'b1,
                       CAP2_BONDED ? capture_pin_two : 1'b1,
                       CAP1_BONDED ? capture_pin_one : 1'b1};
  wire [2:0] edge_sel = {ext_clock_edge_select, capture_edge_two, capture_edge_one};
  logic [2:0] act_edge;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
          s3_r <= 1'b1;
        end else begin
          s1_r <= pin_in[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      // A set select bit means rising edges are active.
      assign act_edge[gi] = edge_sel[gi] ? (s2_r & ~s3_r) : (~s2_r & s3_r);
    end
  endgenerate

  // ==========================================================================
  // Prescaler and counter
  // ==========================================================================
  wire [2:0] psc_term = (timer_clock_select == t16ic_pkg::CLK_DIV2) ? t16ic_pkg::PSC_TERM2 :
                        (timer_clock_select == t16ic_pkg::CLK_DIV8) ? t16ic_pkg::PSC_TERM8 :
                        t16ic_pkg::PSC_TERM4;
  wire psc_hit  = psc_r == psc_term;
  // Halt freezes both the prescaler and the count.
  wire tick     = ~halt_mode & (ext_mode ? act_edge[2] : psc_hit);
  wire ovf_set  = tick & ~reload & (count_r == t16ic_pkg::CNT_MAX);
  wire ovf_clr  = ovf_arm_r & acc & hit_cnt_lo;

  // Halt is tested before the terminal count so a halted prescaler never wraps.
  wire [2:0]  psc_nxt   = (reload | ext_mode) ? 3'h0 :
                          halt_mode ? psc_r :
                          psc_hit ? 3'h0 : psc_r + 3'h1;
  wire [15:0] count_nxt = reload ? t16ic_pkg::CNT_RESET :
                          tick ? count_r + 16'h0001 : count_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      psc_r   <= 3'h0;
      count_r <= t16ic_pkg::CNT_RESET;
    end else begin
      psc_r   <= psc_nxt;
      count_r <= count_nxt;
    end
  end

  // Set wins over a clear arriving in the same cycle.
  wire ovf_flag_nxt = ovf_set | (overflow_flag_r & ~ovf_clr);
  wire ovf_arm_nxt  = (rd_sr & overflow_flag_r) | (ovf_arm_r & ~ovf_clr);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overflow_flag_r <= 1'b0;
      ovf_arm_r       <= 1'b0;
    end else begin
      overflow_flag_r <= ovf_flag_nxt;
      ovf_arm_r       <= ovf_arm_nxt;
    end
  end

  // ==========================================================================
  // Two-byte read latch
  // ==========================================================================
  // The low byte is frozen only by the first high-byte read of a sequence.
  wire       lat_v_nxt = rd_hi | (lat_v_r & ~rd_lo);
  wire [7:0] lat_nxt   = (rd_hi & ~lat_v_r) ? count_r[7:0] : lat_r;
  wire [7:0] low_view  = lat_v_r ? lat_r : count_r[7:0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lat_v_r <= 1'b0;
      lat_r   <= 8'h00;
    end else begin
      lat_v_r <= lat_v_nxt;
      lat_r   <= lat_nxt;
    end
  end

  // ==========================================================================
  // Capture channels
  // ==========================================================================
  // Channel one is disabled and captures nothing in one-pulse or PWM mode.
  wire [1:0] cap_en = {1'b1, ~(one_pulse_select | pwm_select)};

  generate
    for (gi = 0; gi < 2; gi++) begin : g_cap
      wire clr  = cap_arm_r[gi] & acc & hit_cap_lo[gi];
      assign cap_ev[gi] = act_edge[gi] & cap_en[gi] & ~cap_blk_r[gi];
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          cap_r[gi]      <= t16ic_pkg::CAP_RESET;
          cap_flag_r[gi] <= 1'b0;
          cap_arm_r[gi]  <= 1'b0;
          cap_blk_r[gi]  <= 1'b0;
        end else begin
          if (cap_ev[gi]) begin
            cap_r[gi] <= count_r;
          end
          cap_flag_r[gi] <= cap_ev[gi] | (cap_flag_r[gi] & ~clr);
          cap_arm_r[gi]  <= (rd_sr & cap_flag_r[gi]) | (cap_arm_r[gi] & ~clr);
          cap_blk_r[gi]  <= (rd & hit_cap_hi[gi]) | (cap_blk_r[gi] & ~(rd & hit_cap_lo[gi]));
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Interrupt requests
  // ==========================================================================
  assign overflow_irq = overflow_flag_r & overflow_irq_enable & ~irq_mask;
  assign capture_irq  = (|cap_flag_r) & capture_irq_enable & ~irq_mask;

  // ==========================================================================
  // Register writes, read mux and acknowledge
  // ==========================================================================
  wire [7:0] status_view = {cap_flag_r[0], cap_flag_r[1], overflow_flag_r, 5'h00};

  assign rdata = hit_cr1         ? control_reg_one_r :
                 hit_cr2         ? control_reg_two_r :
                 hit_sr          ? status_view :
                 (hit_cnt_hi | hit_alt_hi) ? count_r[15:8] :
                 (hit_cnt_lo | hit_alt_lo) ? low_view :
                 hit_cap_hi[0]   ? cap_r[0][15:8] :
                 hit_cap_lo[0]   ? cap_r[0][7:0] :
                 hit_cap_hi[1]   ? cap_r[1][15:8] :
                 hit_cap_lo[1]   ? cap_r[1][7:0] : 8'h00;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_r             <= 1'b0;
      wb_dat_o          <= 32'h00000000;
      control_reg_one_r <= t16ic_pkg::CR_RESET;
      control_reg_two_r <= t16ic_pkg::CR_RESET;
    end else begin
      ack_r <= acc;
      if (rd) begin
        wb_dat_o <= {24'h000000, rdata};
      end
      if (wr & hit_cr1) begin
        control_reg_one_r <= wb_dat_i[7:0];
      end
      if (wr & hit_cr2) begin
        control_reg_two_r <= wb_dat_i[7:0];
      end
    end
  end

  assign wb_ack_o = ack_r;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_ovf_armed;
    rd_sr && overflow_flag_r;
  endsequence

  sequence s_ovf_cleared;
    acc && hit_cnt_lo && !ovf_set;
  endsequence

  sequence s_cap_hi_read;
    rd && hit_cap_hi[0];
  endsequence

  chk_reload_value: assert property (reload |=> count_r == 16'hFFFC)
    else $error("Low byte write did not reload the counter.");

  chk_wrap_flag: assert property (ovf_set |=> overflow_flag_r && count_r == 16'h0000)
    else $error("Wrap did not set the overflow flag.");

  chk_ovf_clear_seq: assert property (s_ovf_armed ##[1:20] s_ovf_cleared |=> !overflow_flag_r)
    else $error("Overflow flag not cleared by status read then low access.");

  chk_flag_fall_cause: assert property ($fell(overflow_flag_r) |-> $past(acc && hit_cnt_lo && ovf_arm_r))
    else $error("Overflow flag cleared without the clearing sequence.");

  chk_alt_no_clear: assert property (acc && hit_alt_lo && overflow_flag_r |=> overflow_flag_r)
    else $error("Alternate low access cleared the overflow flag.");

  chk_latch_hold: assert property (lat_v_r && rd_hi |=> $stable(lat_r) && lat_v_r)
    else $error("Latched low byte changed on repeated high read.");

  chk_live_low: assert property (rd_lo && !lat_v_r |=> wb_dat_o[7:0] == $past(count_r[7:0]))
    else $error("Low byte read did not return the live count.");

  chk_halt_stop: assert property (halt_mode && !reload |=> count_r == $past(count_r))
    else $error("Counter moved during halt.");

  chk_ext_tick: assert property (ext_mode && act_edge[2] && !halt_mode && !reload
                                 |=> count_r == $past(count_r) + 16'h0001)
    else $error("External edge did not advance the counter.");

  chk_div_two: assert property (timer_clock_select == 2'h1 && tick && !reload |=> !tick)
    else $error("Divide-by-two tick came on two adjacent cycles.");

  chk_cap_copy: assert property (cap_ev[1] |=> cap_r[1] == $past(count_r) && cap_flag_r[1])
    else $error("Capture did not copy the count and set the flag.");

  chk_cap_block: assert property (cap_blk_r[0] |=> $stable(cap_r[0]) && !$rose(cap_flag_r[0]))
    else $error("Capture register or flag changed while blocked.");

  chk_cap_block_set: assert property (s_cap_hi_read |=> cap_blk_r[0])
    else $error("Capture high byte read did not block the channel.");

  chk_pulse_mode_ch1: assert property (one_pulse_select || pwm_select |-> !cap_ev[0])
    else $error("Channel one captured in pulse mode.");

  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held for more than one cycle.");

  chk_ack_follow: assert property (acc |=> wb_ack_o)
    else $error("Accepted access was not acknowledged in the next cycle.");

  chk_wr_ctrl: assert property (wr && hit_cr2 |=> control_reg_two_r == $past(wb_dat_i[7:0]))
    else $error("Control register two write did not land.");

  chk_latch_take: assert property (rd_hi && !lat_v_r |=> lat_v_r && lat_r == $past(count_r[7:0]))
    else $error("First high byte read did not latch the low byte.");

  chk_live_hi: assert property (rd_hi |=> wb_dat_o[7:0] == $past(count_r[15:8]))
    else $error("High byte read did not return the count high byte.");

  chk_latch_free: assert property (rd_lo |=> !lat_v_r)
    else $error("Low byte read did not end the two-byte sequence.");

  chk_ovf_hold: assert property (overflow_flag_r && !(acc && hit_cnt_lo) |=> overflow_flag_r)
    else $error("Overflow flag dropped without a count low access.");

  chk_count_step: assert property (tick && !reload |=> count_r == $past(count_r) + 16'h0001)
    else $error("Tick did not advance the counter by one.");

  chk_count_hold: assert property (!tick && !reload |=> $stable(count_r))
    else $error("Counter moved without a tick.");

  chk_halt_psc: assert property (halt_mode && !reload && !ext_mode |=> $stable(psc_r))
    else $error("Prescaler moved during halt.");

  chk_ovf_irq_gate: assert property (overflow_irq |-> overflow_flag_r && overflow_irq_enable && !irq_mask)
    else $error("Overflow interrupt raised without flag, enable and open mask.");

  chk_ovf_irq_pending: assert property (overflow_flag_r && overflow_irq_enable && !irq_mask |-> overflow_irq)
    else $error("Pending overflow interrupt not raised.");

  chk_cap_irq_gate: assert property (capture_irq |-> cap_flag_r != 2'h0 && capture_irq_enable && !irq_mask)
    else $error("Capture interrupt raised without flag, enable and open mask.");

  chk_cap_irq_pending: assert property (cap_flag_r != 2'h0 && capture_irq_enable && !irq_mask |-> capture_irq)
    else $error("Pending capture interrupt not raised.");

  chk_cap_copy_one: assert property (cap_ev[0] |=> cap_r[0] == $past(count_r) && cap_flag_r[0])
    else $error("Channel one capture did not copy the count and set the flag.");

  chk_cap_flag_fall: assert property ($fell(cap_flag_r[0]) |-> $past(acc && hit_cap_lo[0] && cap_arm_r[0]))
    else $error("Capture flag cleared without the clearing sequence.");

  chk_cap_ch2_free: assert property (act_edge[1] && !cap_blk_r[1] |-> cap_ev[1])
    else $error("Channel two missed an unblocked capture edge.");
endmodule

// >>> core/t16ic_pkg.sv
// Register map, field layout and reset values of the 16-bit capture timer.
package t16ic_pkg;
  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [5:0] ADR_CTRL1   = 6'h00;
  localparam logic [5:0] ADR_CTRL2   = 6'h04;
  localparam logic [5:0] ADR_STATUS  = 6'h08;
  localparam logic [5:0] ADR_CNT_HI  = 6'h0C;
  localparam logic [5:0] ADR_CNT_LO  = 6'h10;
  localparam logic [5:0] ADR_ALT_HI  = 6'h14;
  localparam logic [5:0] ADR_ALT_LO  = 6'h18;
  localparam logic [5:0] ADR_CAP1_HI = 6'h1C;
  localparam logic [5:0] ADR_CAP1_LO = 6'h20;
  localparam logic [5:0] ADR_CAP2_HI = 6'h24;
  localparam logic [5:0] ADR_CAP2_LO = 6'h28;
  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CR1_CAP_IRQ_EN  = 7;
  localparam int CR1_CAP_EDGE1   = 6;
  localparam int CR1_OVF_IRQ_EN  = 5;
  localparam int CR2_ONE_PULSE   = 7;
  localparam int CR2_PWM         = 6;
  localparam int CR2_CLKSEL_HI   = 3;
  localparam int CR2_CLKSEL_LO   = 2;
  localparam int CR2_CAP_EDGE2   = 1;
  localparam int CR2_EXT_EDGE    = 0;
  localparam int SR_CAP_FLAG1    = 7;
  localparam int SR_CAP_FLAG2    = 6;
  localparam int SR_OVF_FLAG     = 5;
  // ==========================================================================
  // Clock select codes and prescaler terminal counts
  // ==========================================================================
  localparam logic [1:0] CLK_DIV4   = 2'h0;
  localparam logic [1:0] CLK_DIV2   = 2'h1;
  localparam logic [1:0] CLK_DIV8   = 2'h2;
  localparam logic [1:0] CLK_EXT    = 2'h3;
  localparam logic [2:0] PSC_TERM2  = 3'h1;
  localparam logic [2:0] PSC_TERM4  = 3'h3;
  localparam logic [2:0] PSC_TERM8  = 3'h7;
  // ==========================================================================
  // Reset values and counter maximum
  // ==========================================================================
  localparam logic [15:0] CNT_RESET = 16'hFFFC;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] CAP_RESET = 16'h0000;
  localparam logic [7:0]  CR_RESET  = 8'h00;
endpackage

// >>> bench/t16ic_pin_src.sv
// Behavioural model of the signal sources on the capture pins and the external clock pin.
`timescale 1ns/1ps
module t16ic_pin_src (
  input  wire logic sys_clk,
  output logic      cap_one,
  output logic      cap_two,
  output logic      ext_clk
);
  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  // Idle pins sit high, so the synchronisers see no edge at reset release.
  initial begin
    cap_one = 1'b1;
    cap_two = 1'b1;
    ext_clk = 1'b1;
  end

  // Moves one capture pin and waits until the synchronised edge has landed.
  task automatic set_cap(input int ch, input logic lvl);
    @(posedge sys_clk);
    if (ch == 1) begin
      cap_one <= lvl;
    end else begin
      cap_two <= lvl;
    end
    repeat (6) @(posedge sys_clk);
  endtask

  // Gives whole external clock periods of nine CPU clocks, one active edge each.
  task automatic ext_ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      ext_clk <= 1'b0;
      repeat (4) @(posedge sys_clk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask
endmodule

// >>> bench/tb.sv
// Self-checking testbench of the 16-bit capture timer driven over Wishbone.
`timescale 1ns/1ps
module tb;
  logic        sys_clk;
  logic        rst;
  logic        wb_cyc, wb_stb, wb_we, irq_mask, halt_mode;
  logic [5:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic        wb_ack, ovf_irq, cap_irq, cap_one, cap_two, ext_clk;
  logic [7:0]  rd;
  logic [1:0]  codes [3] = '{t16ic_pkg::CLK_DIV2, t16ic_pkg::CLK_DIV4, t16ic_pkg::CLK_DIV8};
  int          divs  [3] = '{2, 4, 8};
  int          error_cnt, samples_checked;

  t16ic_timer dut (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .wb_cyc_i        (wb_cyc),
    .wb_stb_i        (wb_stb),
    .wb_we_i         (wb_we),
    .wb_adr_i        (wb_adr),
    .wb_sel_i        (wb_sel),
    .wb_dat_i        (wb_dat_w),
    .wb_dat_o        (wb_dat_r),
    .wb_ack_o        (wb_ack),
    .irq_mask        (irq_mask),
    .halt_mode       (halt_mode),
    .capture_pin_one (cap_one),
    .capture_pin_two (cap_two),
    .ext_clock_pin   (ext_clk),
    .overflow_irq    (ovf_irq),
    .capture_irq     (cap_irq)
  );
  t16ic_pin_src src (.sys_clk(sys_clk), .cap_one(cap_one), .cap_two(cap_two), .ext_clk(ext_clk));

  // ==========================================================================
  // Clock, bus tasks and report
  // ==========================================================================
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  task automatic wb_acc(input logic we, input logic [5:0] adr, input logic [7:0] wd);
    int n;
    n = 0;
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= adr;
    wb_dat_w <= {24'h000000, wd};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      $display("ERROR wb_ack expected 1 seen 0");
    end
    rd = wb_dat_r[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input string what, input logic [5:0] adr, input logic [7:0] exp);
    wb_acc(1'b0, adr, 8'h00);
    check(what, exp, rd);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    $display("ERROR watchdog expected finish seen timeout");
    end_sim();
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    logic [7:0] a;
    error_cnt = 0;
    samples_checked = 0;
    rst = 1'b1;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} = '0;
    wb_sel = 4'h1;
    irq_mask = 1'b1;
    halt_mode = 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rchk("cnt_hi", t16ic_pkg::ADR_CNT_HI, 8'hFF);
    rchk("cnt_lo", t16ic_pkg::ADR_CNT_LO, 8'hFC);
    rchk("alt_hi", t16ic_pkg::ADR_ALT_HI, 8'hFF);
    rchk("alt_lo", t16ic_pkg::ADR_ALT_LO, 8'hFC);
    rchk("ctrl1", t16ic_pkg::ADR_CTRL1, 8'h00);
    rchk("status", t16ic_pkg::ADR_STATUS, 8'h00);
    halt_mode <= 1'b0;
    // Live reads spaced a whole number of prescaler periods apart differ by exactly 16.
    for (int i = 0; i < 3; i++) begin
      wb_acc(1'b1, t16ic_pkg::ADR_CTRL2, {4'h0, codes[i], 2'h0});
      wb_acc(1'b0, t16ic_pkg::ADR_CNT_LO, 8'h00);
      a = rd;
      repeat (16 * divs[i] - 3) @(posedge sys_clk);
      wb_acc(1'b0, t16ic_pkg::ADR_CNT_LO, 8'h00);
      check("tick_delta", 8'h10, rd - a);
    end
    wb_acc(1'b1, t16ic_pkg::ADR_CTRL2, 8'h0D);
    wb_acc(1'b0, t16ic_pkg::ADR_STATUS, 8'h00);
    wb_acc(1'b1, t16ic_pkg::ADR_CNT_LO, 8'h55);
    rchk("cnt_hi_ext", t16ic_pkg::ADR_CNT_HI, 8'hFF);
    src.ext_ticks(2);
    rchk("cnt_hi_rep", t16ic_pkg::ADR_CNT_HI, 8'hFF);
    rchk("cnt_lo_latch", t16ic_pkg::ADR_CNT_LO, 8'hFC);
    rchk("cnt_lo_live", t16ic_pkg::ADR_CNT_LO, 8'hFE);
    wb_acc(1'b1, t16ic_pkg::ADR_CTRL2, 8'h0C);
    src.ext_ticks(1);
    rchk("cnt_lo_fall", t16ic_pkg::ADR_CNT_LO, 8'hFF);
    wb_acc(1'b1, t16ic_pkg::ADR_CTRL1, 8'h20);
    src.ext_ticks(1);
    rchk("status_ovf", t16ic_pkg::ADR_STATUS, 8'h20);
    rchk("alt_lo_wrap", t16ic_pkg::ADR_ALT_LO, 8'h00);
    rchk("status_kept", t16ic_pkg::ADR_STATUS, 8'h20);
    check("ovf_irq_masked", 8'h00, {7'h00, ovf_irq});
    irq_mask <= 1'b0;
    @(posedge sys_clk);
    check("ovf_irq", 8'h01, {7'h00, ovf_irq});
    rchk("cnt_lo_clr", t16ic_pkg::ADR_CNT_LO, 8'h00);
    rchk("status_clr", t16ic_pkg::ADR_STATUS, 8'h00);
    check("ovf_irq_clr", 8'h00, {7'h00, ovf_irq});
    wb_acc(1'b1, t16ic_pkg::ADR_CTRL1, 8'hC0);
    src.set_cap(1, 1'b0);
    rchk("status_nocap", t16ic_pkg::ADR_STATUS, 8'h00);
    src.set_cap(1, 1'b1);
    rchk("status_cap1", t16ic_pkg::ADR_STATUS, 8'h80);
    check("cap_irq", 8'h01, {7'h00, cap_irq});
    rchk("cap1_hi", t16ic_pkg::ADR_CAP1_HI, 8'h00);
    src.ext_ticks(2);
    src.set_cap(1, 1'b0);
    src.set_cap(1, 1'b1);
    rchk("cap1_lo_blk", t16ic_pkg::ADR_CAP1_LO, 8'h00);
    rchk("status_blk", t16ic_pkg::ADR_STATUS, 8'h00);
    check("cap_irq_clr", 8'h00, {7'h00, cap_irq});
    src.set_cap(1, 1'b0);
    src.set_cap(1, 1'b1);
    rchk("cap1_hi_new", t16ic_pkg::ADR_CAP1_HI, 8'h00);
    rchk("cap1_lo_new", t16ic_pkg::ADR_CAP1_LO, 8'h02);
    src.set_cap(2, 1'b0);
    rchk("status_both", t16ic_pkg::ADR_STATUS, 8'hC0);
    rchk("cap1_lo_clr", t16ic_pkg::ADR_CAP1_LO, 8'h02);
    rchk("cap2_lo_clr", t16ic_pkg::ADR_CAP2_LO, 8'h02);
    rchk("status_none", t16ic_pkg::ADR_STATUS, 8'h00);
    wb_acc(1'b1, t16ic_pkg::ADR_CTRL2, 8'h8E);
    src.ext_ticks(1);
    src.set_cap(1, 1'b0);
    src.set_cap(1, 1'b1);
    src.set_cap(2, 1'b1);
    rchk("status_opm", t16ic_pkg::ADR_STATUS, 8'h40);
    rchk("cap2_lo_opm", t16ic_pkg::ADR_CAP2_LO, 8'h03);
    wb_acc(1'b1, t16ic_pkg::ADR_CTRL2, 8'h44);
    src.set_cap(1, 1'b0);
    src.set_cap(1, 1'b1);
    rchk("status_pwm", t16ic_pkg::ADR_STATUS, 8'h00);
    halt_mode <= 1'b1;
    wb_acc(1'b0, t16ic_pkg::ADR_CNT_LO, 8'h00);
    a = rd;
    repeat (40) @(posedge sys_clk);
    rchk("cnt_lo_halt", t16ic_pkg::ADR_CNT_LO, a);
    wb_acc(1'b1, t16ic_pkg::ADR_ALT_LO, 8'h00);
    rchk("alt_hi_reload", t16ic_pkg::ADR_ALT_HI, 8'hFF);
    rchk("alt_lo_reload", t16ic_pkg::ADR_ALT_LO, 8'hFC);
    // Let the count run away from FFFC, then restart it with a reset while halted.
    halt_mode <= 1'b0;
    repeat (40) @(posedge sys_clk);
    halt_mode <= 1'b1;
    rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rchk("cnt_hi_rst", t16ic_pkg::ADR_CNT_HI, 8'hFF);
    rchk("cnt_lo_rst", t16ic_pkg::ADR_CNT_LO, 8'hFC);
    rchk("ctrl2_rst", t16ic_pkg::ADR_CTRL2, 8'h00);
    rchk("status_rst", t16ic_pkg::ADR_STATUS, 8'h00);
    end_sim();
  end
endmodule
